// ===== logic/cal_select.sv
`timescale 1ns/10ps
module cal_select
   import fuse_trim_pkg::*;
(
   // constant set
   input wire logic [CAL_W-1:0] cal,
   // channel selection
   input wire logic current_path_select,
   input wire logic [1:0] gain_field,
   input wire logic [2:0] volt_const_selector,
   // chosen constant
   output logic [CONST_W-1:0] sel_const
);
   localparam logic [3:0] CUR_N = 4'(N_CUR);

   logic [CONST_W-1:0] k [N_CONST];
   logic [3:0] vidx;

   // unpack, first constant in the top bits
   for (genvar g = 0; g < N_CONST; g++)
   begin : g_unpack
      assign k[g] = cal[CAL_W - 1 - g * CONST_W -: CONST_W];
   end

   assign vidx = CUR_N + {1'b0, volt_const_selector};

   // current path picks by gain, voltage path by selector
   always_comb
   begin
      if (current_path_select)
         sel_const = k[{2'b00, gain_field}];
      else if (volt_const_selector < VSEL_FIXED_MIN)
         sel_const = k[vidx];
      else
         sel_const = CAL_DEFAULT; // fixed codes
   end
endmodule

// ===== logic/fuse_calibration_trim_store.sv
`timescale 1ns/10ps
module fuse_calibration_trim_store
   import fuse_trim_pkg::*;
#(
   parameter int unsigned FUSE_HALF = FUSE_HALF_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // fuse cell readout pins
   output logic fuse_rd_clk,
   output logic fuse_rd_en,
   input wire logic fuse_rd_data,
   // mode 8 register access from the serial host interface
   input wire logic host_sel_cal,
   input wire logic host_begin,
   input wire logic host_shift,
   input wire logic host_bit_in,
   input wire logic host_commit,
   output logic host_bit_out,
   // active channel configuration
   input wire logic current_path_select,
   input wire logic [1:0] gain_field,
   input wire logic [2:0] volt_const_selector,
   // measurement correction towards the signal processor
   input wire logic meas_start,
   output logic cal_valid,
   output logic [CONST_W-1:0] cal_const,
   // trim outputs towards the analog blocks
   output logic [TRIM_W-1:0] trim_total,
   output logic [TRIM_FLD_W-1:0] trim_current_source,
   output logic [TRIM_FLD_W-1:0] trim_amp_offset,
   output logic [TRIM_FLD_W-1:0] trim_ref_abs,
   output logic [TRIM_FLD_W-1:0] trim_ref_tc,
   output logic [5:0] trim_current_steps,
   // status
   output logic shadow_loaded,
   output logic [SPARE_W-1:0] fuse_spare_field
);
   // -----------------------------------------------------------
   // state
   // -----------------------------------------------------------
   typedef struct packed {
      logic [CAL_W-1:0] cal;
      logic [TRIM_W-1:0] trim;
      logic [CAL_W-1:0] stage;
      logic loaded;
      logic pend;
      logic [CONST_W-1:0] cal_out;
      logic cal_vld;
      logic [5:0] steps;
   } top_s;

   top_s r_reg;
   top_s r_next;

   logic [CONST_W-1:0] sel_const;
   logic [CAL_W-1:0] fuse_cal_field;
   logic [TRIM_W-1:0] fuse_trim_field;
   logic [TRIM_W-1:0] stage_trim;
   logic [TRIM_FLD_W-1:0] src_trim;

   fuse_ld_if fuse_ld ();

   // -----------------------------------------------------------
   // fuse readout and constant selection
   // -----------------------------------------------------------
   fuse_reader #(
      .HALF_CYC(FUSE_HALF)
   ) u_reader (
      .clk(clk),
      .resetn(resetn),
      .ld(fuse_ld),
      .fuse_rd_clk(fuse_rd_clk),
      .fuse_rd_en(fuse_rd_en),
      .fuse_rd_data(fuse_rd_data)
   );

   // selector follows the live channel configuration
   cal_select u_select (
      .cal(r_reg.cal),
      .current_path_select(current_path_select),
      .gain_field(gain_field),
      .volt_const_selector(volt_const_selector),
      .sel_const(sel_const)
   );

   // field slices of the fuse image
   assign fuse_cal_field = fuse_ld.image[CAL_LSB +: CAL_W];
   assign fuse_trim_field = fuse_ld.image[TRIM_LSB +: TRIM_W];
   assign fuse_spare_field = fuse_ld.image[SPARE_LSB +: SPARE_W];
   assign stage_trim = r_reg.stage[TRIM_W-1:0];
   assign src_trim = r_reg.trim[TRIM_SRC_LSB +: TRIM_FLD_W];

   // -----------------------------------------------------------
   // next state
   // -----------------------------------------------------------
   always_comb
   begin
      r_next = r_reg;
      r_next.cal_vld = 1'b0;

      // one-time shadow copy once the array has been read
      if (fuse_ld.done && !r_reg.loaded)
      begin
         r_next.cal = fuse_cal_field;
         r_next.trim = fuse_trim_field;
         r_next.loaded = 1'b1;
      end

      // staging register: loaded for a read, shifted msb first
      if (host_begin)
         r_next.stage = host_sel_cal ? r_reg.cal : CAL_W'(r_reg.trim);
      else if (host_shift)
         r_next.stage = {r_reg.stage[CAL_W-2:0], host_bit_in};

      // host commit comes after the power-up copy so a same-cycle write wins
      if (host_commit)
      begin
         if (host_sel_cal)
            r_next.cal = r_reg.stage;
         else
            r_next.trim = stage_trim;
      end

      // constant is taken when the measurement starts, so a committed
      // write is seen by the next start at the latest
      if (meas_start || r_reg.pend)
      begin
         if (r_reg.loaded)
         begin
            r_next.cal_out = sel_const;
            r_next.cal_vld = 1'b1;
            r_next.pend = 1'b0;
         end
         else
            r_next.pend = 1'b1; // held back until shadows are loaded
      end

      // one signed step count serves every current range
      if (src_trim[TRIM_FLD_W-1])
         r_next.steps = TRIM_STEP_SPAN - {2'b00, src_trim[3:0]};
      else
         r_next.steps = 6'h00 - {2'b00, src_trim[3:0]};
   end

   // -----------------------------------------------------------
   // registers
   // -----------------------------------------------------------
   // shadows start from the documented defaults until the copy
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         r_reg <= '{
            cal: CAL_RESET,
            trim: TRIM_RESET,
            stage: '0,
            loaded: 1'b0,
            pend: 1'b0,
            cal_out: CAL_DEFAULT,
            cal_vld: 1'b0,
            steps: 6'h00
         };
      else
         r_reg <= r_next;
   end

   // -----------------------------------------------------------
   // outputs
   // -----------------------------------------------------------
   // read data leaves msb first for either register width
   assign host_bit_out = host_sel_cal ? r_reg.stage[CAL_W-1] : r_reg.stage[TRIM_W-1];
   assign cal_valid = r_reg.cal_vld;
   assign cal_const = r_reg.cal_out;
   assign shadow_loaded = r_reg.loaded;
   assign trim_total = r_reg.trim;
   // field order within the trim register
   assign trim_current_source = r_reg.trim[TRIM_SRC_LSB +: TRIM_FLD_W];
   assign trim_amp_offset = r_reg.trim[TRIM_AMP_LSB +: TRIM_FLD_W];
   assign trim_ref_abs = r_reg.trim[TRIM_REF_ABS_LSB +: TRIM_FLD_W];
   assign trim_ref_tc = r_reg.trim[TRIM_REF_TC_LSB +: TRIM_FLD_W];
   assign trim_current_steps = r_reg.steps;

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   property p_cal_copy;
      @(posedge clk) disable iff (!resetn)
         fuse_ld.done && !r_reg.loaded && !host_commit |=> r_reg.cal == $past(fuse_cal_field);
   endproperty
   a_cal_copy: assert property (p_cal_copy) else $error("calibration copy wrong");

   property p_trim_copy;
      @(posedge clk) disable iff (!resetn)
         fuse_ld.done && !r_reg.loaded && !host_commit |=> trim_total == $past(fuse_trim_field);
   endproperty
   a_trim_copy: assert property (p_trim_copy) else $error("trim copy wrong");

   property p_cal_write;
      @(posedge clk) disable iff (!resetn)
         host_commit && host_sel_cal |=> r_reg.cal == $past(r_reg.stage);
   endproperty
   a_cal_write: assert property (p_cal_write) else $error("constant write lost");

   property p_trim_write;
      @(posedge clk) disable iff (!resetn)
         host_commit && !host_sel_cal |=> trim_total == $past(stage_trim);
   endproperty
   a_trim_write: assert property (p_trim_write) else $error("trim write lost");

   property p_cur_first;
      @(posedge clk) disable iff (!resetn)
         current_path_select && gain_field == 2'b00 |-> sel_const == r_reg.cal[CAL_W-1 -: CONST_W];
   endproperty
   a_cur_first: assert property (p_cur_first) else $error("current constant wrong");

   property p_volt_fixed;
      @(posedge clk) disable iff (!resetn)
         !current_path_select && volt_const_selector >= VSEL_FIXED_MIN |-> sel_const == CAL_DEFAULT;
   endproperty
   a_volt_fixed: assert property (p_volt_fixed) else $error("fixed constant wrong");

   property p_no_early;
      @(posedge clk) disable iff (!resetn)
         meas_start && !shadow_loaded |=> !cal_valid && r_reg.pend;
   endproperty
   a_no_early: assert property (p_no_early) else $error("measurement before load");

   property p_meas_const;
      @(posedge clk) disable iff (!resetn)
         meas_start && shadow_loaded |=> cal_valid && cal_const == $past(sel_const);
   endproperty
   a_meas_const: assert property (p_meas_const) else $error("constant not applied");

   property p_src_steps;
      @(posedge clk) disable iff (!resetn)
         trim_current_source == 5'h10 ##1 $stable(trim_current_source)
            |-> trim_current_steps == TRIM_STEP_SPAN;
   endproperty
   a_src_steps: assert property (p_src_steps) else $error("source step count wrong");

   // -----------------------------------------------------------
   // selection and measurement checks
   // -----------------------------------------------------------
   // outer constants of both paths sit where the layout puts them
   property p_cur_last;
      @(posedge clk) disable iff (!resetn)
         current_path_select && gain_field == 2'b11
            |-> sel_const == r_reg.cal[CAL_W - N_CUR * CONST_W +: CONST_W];
   endproperty
   a_cur_last: assert property (p_cur_last) else $error("top gain pick wrong");

   property p_volt_first;
      @(posedge clk) disable iff (!resetn)
         !current_path_select && volt_const_selector == 3'h0
            |-> sel_const == r_reg.cal[CAL_W - N_CUR * CONST_W - 1 -: CONST_W];
   endproperty
   a_volt_first: assert property (p_volt_first) else $error("first volt pick wrong");

   property p_volt_last;
      @(posedge clk) disable iff (!resetn)
         !current_path_select && volt_const_selector == 3'h5
            |-> sel_const == r_reg.cal[CONST_W-1:0];
   endproperty
   a_volt_last: assert property (p_volt_last) else $error("last volt pick wrong");

   // the constant only moves together with its valid pulse
   property p_const_hold;
      @(posedge clk) disable iff (!resetn) !cal_valid |-> $stable(cal_const);
   endproperty
   a_const_hold: assert property (p_const_hold) else $error("constant moved alone");

   property p_vld_cause;
      @(posedge clk) disable iff (!resetn) cal_valid |-> $past(meas_start) || $past(r_reg.pend);
   endproperty
   a_vld_cause: assert property (p_vld_cause) else $error("valid without request");

   // a pending request is served on the first cycle after loading
   property p_pend_served;
      @(posedge clk) disable iff (!resetn) r_reg.pend && shadow_loaded |=> cal_valid;
   endproperty
   a_pend_served: assert property (p_pend_served) else $error("pending request lost");

   // nothing may be corrected with the reset defaults
   property p_quiet_unloaded;
      @(posedge clk) disable iff (!resetn) !shadow_loaded |-> !cal_valid;
   endproperty
   a_quiet_unloaded: assert property (p_quiet_unloaded) else $error("valid before load");

   // the power-up copy happens once and is never undone
   property p_loaded_hold;
      @(posedge clk) disable iff (!resetn) shadow_loaded |=> shadow_loaded;
   endproperty
   a_loaded_hold: assert property (p_loaded_hold) else $error("load flag dropped");

   // negative source trims count down by the magnitude
   property p_src_minus;
      @(posedge clk) disable iff (!resetn)
         !trim_current_source[TRIM_FLD_W-1] ##1 $stable(trim_current_source)
            |-> trim_current_steps + {2'b00, trim_current_source[3:0]} == 6'h00;
   endproperty
   a_src_minus: assert property (p_src_minus) else $error("minus step count wrong");

   property p_cov_load;
      @(posedge clk) disable iff (!resetn) $rose(shadow_loaded);
   endproperty
   c_cov_load: cover property (p_cov_load);

   property p_cov_cur;
      @(posedge clk) disable iff (!resetn) cal_valid && current_path_select;
   endproperty
   c_cov_cur: cover property (p_cov_cur);

   property p_cov_write;
      @(posedge clk) disable iff (!resetn) host_commit && host_sel_cal && shadow_loaded;
   endproperty
   c_cov_write: cover property (p_cov_write);

   property p_cov_pend;
      @(posedge clk) disable iff (!resetn) r_reg.pend ##1 cal_valid;
   endproperty
   c_cov_pend: cover property (p_cov_pend);
endmodule

// ===== logic/fuse_ld_if.sv
`timescale 1ns/10ps
interface fuse_ld_if;
   import fuse_trim_pkg::*;
   logic [FUSE_BITS-1:0] image;
   logic done;
   modport reader (output image, output done);
   modport store (input image, input done);
endinterface

// ===== logic/fuse_reader.sv
`timescale 1ns/10ps
module fuse_reader
   import fuse_trim_pkg::*;
#(
   parameter int unsigned HALF_CYC = FUSE_HALF_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // fuse image towards the store
   fuse_ld_if.reader ld,
   // fuse cell readout pins
   output logic fuse_rd_clk,
   output logic fuse_rd_en,
   input wire logic fuse_rd_data
);
   // -----------------------------------------------------------
   // parameter checks
   // -----------------------------------------------------------
   if (HALF_CYC < 8 || HALF_CYC > 255 || 2 * HALF_CYC * FUSE_MAX_HZ < CLK_HZ)
   begin : g_bad_half
      $error("fuse read half period out of range");
   end

   localparam logic [7:0] DIV_LAST = 8'(HALF_CYC - 1);
   localparam logic [7:0] IDX_LAST = 8'(FUSE_BITS - 1);

   typedef struct packed {
      load_state_e st;
      logic [7:0] div;
      logic [7:0] idx;
      logic sclk;
      logic [1:0] sync;
      logic [FUSE_BITS-1:0] img;
   } rd_s;

   rd_s r_reg;
   rd_s r_next;

   // one bit per read clock period; sampled at the end of the high half
   always_comb
   begin
      r_next = r_reg;
      r_next.sync = {r_reg.sync[0], fuse_rd_data};
      case (r_reg.st)
         LD_IDLE:
         begin
            r_next.st = LD_READ;
            r_next.div = 8'h00;
         end
         LD_READ:
         begin
            if (r_reg.div == DIV_LAST)
            begin
               r_next.div = 8'h00;
               r_next.sclk = ~r_reg.sclk; // slow cells, never above the rate limit
               if (r_reg.sclk)
               begin
                  r_next.img[r_reg.idx] = r_reg.sync[1]; // whole array captured
                  if (r_reg.idx == IDX_LAST)
                     r_next.st = LD_DONE;
                  else
                     r_next.idx = r_reg.idx + 8'h01;
               end
            end
            else
               r_next.div = r_reg.div + 8'h01;
         end
         LD_DONE:
            r_next.sclk = 1'b0;
         default:
            r_next.st = LD_IDLE;
      endcase
   end

   // unread bits keep their unprogrammed defaults
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         r_reg <= '{st: LD_IDLE, div: 8'h00, idx: 8'h00, sclk: 1'b0, sync: 2'h0, img: FUSE_RESET};
      else
         r_reg <= r_next;
   end

   assign fuse_rd_clk = r_reg.sclk;
   assign fuse_rd_en = (r_reg.st == LD_READ);
   assign ld.image = r_reg.img;
   assign ld.done = (r_reg.st == LD_DONE);

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   property p_fuse_high;
      @(posedge clk) disable iff (!resetn) $rose(fuse_rd_clk) |-> fuse_rd_clk [*8];
   endproperty
   a_fuse_high: assert property (p_fuse_high) else $error("fuse clock high too short");

   property p_fuse_low;
      @(posedge clk) disable iff (!resetn) $fell(fuse_rd_clk) && fuse_rd_en |-> !fuse_rd_clk [*8];
   endproperty
   a_fuse_low: assert property (p_fuse_low) else $error("fuse clock low too short");

   property p_load_done;
      @(posedge clk) disable iff (!resetn) $rose(ld.done);
   endproperty
   c_load_done: cover property (p_load_done);
endmodule

// ===== logic/fuse_trim_pkg.sv
package fuse_trim_pkg;
   // -----------------------------------------------------------
   // clocking and fuse readout rate
   // -----------------------------------------------------------
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned FUSE_MAX_HZ = 500_000;
   // least half period of the fuse read clock, rounded up
   localparam int unsigned FUSE_HALF_CYC = (CLK_HZ + 2 * FUSE_MAX_HZ - 1) / (2 * FUSE_MAX_HZ);

   // -----------------------------------------------------------
   // fuse array layout
   // -----------------------------------------------------------
   localparam int FUSE_BITS = 188;
   localparam int SPARE_LSB = 183;
   localparam int SPARE_W = 5;
   localparam int TRIM_LSB = 163;
   localparam int TRIM_W = 20;
   localparam int CAL_LSB = 53;
   localparam int CAL_W = 110;
   localparam int TEST_W = 53;

   // -----------------------------------------------------------
   // constants and trim fields
   // -----------------------------------------------------------
   localparam int CONST_W = 11;
   localparam int N_CONST = 10;
   localparam int N_CUR = 4;
   localparam int TRIM_FLD_W = 5;
   localparam int TRIM_SRC_LSB = 15;
   localparam int TRIM_AMP_LSB = 10;
   localparam int TRIM_REF_ABS_LSB = 5;
   localparam int TRIM_REF_TC_LSB = 0;
   localparam logic [CONST_W-1:0] CAL_DEFAULT = 11'h60C;
   localparam logic [SPARE_W-1:0] SPARE_DEFAULT = 5'h0F;
   localparam logic [TRIM_W-1:0] TRIM_RESET = 20'h00000;
   localparam logic [CAL_W-1:0] CAL_RESET = {N_CONST{CAL_DEFAULT}};
   localparam logic [TEST_W-1:0] TEST_RESET = 53'h0;
   localparam logic [FUSE_BITS-1:0] FUSE_RESET = {SPARE_DEFAULT, TRIM_RESET, CAL_RESET, TEST_RESET};
   localparam logic [2:0] VSEL_FIXED_MIN = 3'h6;
   localparam logic [5:0] TRIM_STEP_SPAN = 6'h10;

   // fuse loader states, gray along idle -> read -> done
   typedef enum logic [1:0] {
      LD_IDLE = 2'b00,
      LD_READ = 2'b01,
      LD_DONE = 2'b11
   } load_state_e;
endpackage

// ===== testbench/fuse_cell_model.sv
`timescale 1ns/10ps
module fuse_cell_model
   import fuse_trim_pkg::*;
(
   // fuse readout pins
   input wire logic fuse_rd_clk,
   input wire logic fuse_rd_en,
   output logic fuse_rd_data,
   // programmed cell contents
   input wire logic [FUSE_BITS-1:0] image
);
   // ----------------------------------------
   // cell array readout
   // ----------------------------------------
   int idx = 0;

   // a new read pass starts again at cell 0
   always @(posedge fuse_rd_en)
   begin
      idx = 0;
   end

   // next cell on each falling read clock, index 0 first
   always @(negedge fuse_rd_clk)
   begin
      if (fuse_rd_en)
      begin
         idx = idx + 1;
      end
   end

   // weak cells: released line shows the inverse, never a stale level
   always @(fuse_rd_en or idx or image)
   begin
      if (fuse_rd_en && idx < FUSE_BITS)
      begin
         fuse_rd_data = image[idx];
      end
      else
      begin
         fuse_rd_data = ~fuse_rd_data;
      end
   end

   initial fuse_rd_data = 1'b0;
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
   import fuse_trim_pkg::*;
   localparam int HALF = FUSE_HALF_CYC;
   logic clk, resetn, fuse_rd_clk, fuse_rd_en, fuse_rd_data;
   logic host_sel_cal, host_begin, host_shift, host_bit_in, host_commit, host_bit_out;
   logic current_path_select, meas_start, cal_valid, shadow_loaded, last_rc;
   logic [1:0] gain_field;
   logic [2:0] volt_const_selector;
   logic [CONST_W-1:0] cal_const;
   logic [TRIM_W-1:0] trim_total, tw, tprev;
   logic [TRIM_FLD_W-1:0] t_src, t_amp, t_abs, t_tc;
   logic [5:0] steps;
   logic [SPARE_W-1:0] spare;
   logic [FUSE_BITS-1:0] image;
   logic [CAL_W-1:0] cal_exp, rd;
   logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h0F, 5'h10, 5'h11, 5'h1F};
   int fail_count, samples_checked, run, falls, i;

   // ----------------------------------------
   // design and fuse cells
   // ----------------------------------------
   fuse_calibration_trim_store #(.FUSE_HALF(HALF)) i_dut (
      .clk(clk), .resetn(resetn), .fuse_rd_clk(fuse_rd_clk), .fuse_rd_en(fuse_rd_en),
      .fuse_rd_data(fuse_rd_data), .host_sel_cal(host_sel_cal), .host_begin(host_begin),
      .host_shift(host_shift), .host_bit_in(host_bit_in), .host_commit(host_commit),
      .host_bit_out(host_bit_out), .current_path_select(current_path_select),
      .gain_field(gain_field), .volt_const_selector(volt_const_selector),
      .meas_start(meas_start), .cal_valid(cal_valid), .cal_const(cal_const),
      .trim_total(trim_total), .trim_current_source(t_src), .trim_amp_offset(t_amp),
      .trim_ref_abs(t_abs), .trim_ref_tc(t_tc), .trim_current_steps(steps),
      .shadow_loaded(shadow_loaded), .fuse_spare_field(spare));

   fuse_cell_model i_cells (.fuse_rd_clk(fuse_rd_clk), .fuse_rd_en(fuse_rd_en),
      .fuse_rd_data(fuse_rd_data), .image(image));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [CAL_W-1:0] exp,
                      input logic [CAL_W-1:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
      begin
         $display("Testbench passed");
      end
      else
      begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // one mode 8 frame: reads the old contents while shifting new bits in
   task automatic host_xfer(input logic sel, input int n, input logic [CAL_W-1:0] wr,
                            input logic wr_en, output logic [CAL_W-1:0] rdv);
      rdv = '0;
      @(negedge clk);
      host_sel_cal = sel;
      host_begin = 1'b1;
      for (int k = n - 1; k >= 0; k--)
      begin
         @(negedge clk);
         host_begin = 1'b0;
         rdv[k] = host_bit_out;
         host_shift = 1'b1;
         host_bit_in = wr[k]; // msb first
      end
      @(negedge clk);
      host_shift = 1'b0;
      host_commit = wr_en;
      @(negedge clk);
      host_commit = 1'b0;
   endtask

   // expected constant, worked out from the register layout
   function automatic logic [CONST_W-1:0] pick(input logic [CAL_W-1:0] c, input logic cur,
                                              input logic [1:0] g, input logic [2:0] s);
      if (cur)
      begin
         return c[109 - 11 * g -: 11];
      end
      return (s < 3'h6) ? c[65 - 11 * s -: 11] : 11'h60C;
   endfunction

   task automatic meas(input logic cur, input logic [1:0] g, input logic [2:0] s);
      @(negedge clk);
      current_path_select = cur;
      gain_field = g;
      volt_const_selector = s;
      meas_start = 1'b1;
      @(negedge clk);
      meas_start = 1'b0;
      chk("cal_valid", 1'b1, cal_valid);
      chk("cal_const", pick(cal_exp, cur, g, s), cal_const);
   endtask

   // ----------------------------------------
   // monitors: read clock high time, cell count, no early correction
   // ----------------------------------------
   always @(negedge clk)
   begin
      if (fuse_rd_clk !== last_rc)
      begin
         if (last_rc === 1'b1)
         begin
            falls++;
            chk("rd_clk_high", HALF, run);
         end
         run = 1;
      end
      else
      begin
         run++;
      end
      last_rc = fuse_rd_clk;
      if (cal_valid === 1'b1 && shadow_loaded !== 1'b1)
      begin
         chk("early_valid", 1'b0, cal_valid);
      end
   end

   initial
   begin
      repeat (60000) @(posedge clk);
      fail_count++;
      $display("[FAIL] watchdog expected finish seen timeout");
      close_out();
   end

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial
   begin
      {resetn, host_sel_cal, host_begin, host_shift, host_bit_in, host_commit} = '0;
      {current_path_select, gain_field, volt_const_selector, meas_start} = '0;
      fail_count = 0;
      samples_checked = 0;
      falls = 0;
      run = 0;
      last_rc = 1'b0;
      for (i = 0; i < 10; i++)
      begin
         cal_exp[109 - 11 * i -: 11] = 11'h105 + 11'(i * 147);
      end
      image = {5'h15, 20'hB2C47, cal_exp, 53'h1_2345_6789_ABCD};
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      // power-up: a measurement asked early stays pending
      @(negedge clk);
      current_path_select = 1'b1;
      gain_field = 2'h2;
      meas_start = 1'b1;
      chk("spare_reset", SPARE_DEFAULT, spare);
      chk("trim_reset", 20'h00000, trim_total);
      @(negedge clk);
      meas_start = 1'b0;
      host_xfer(1'b1, CAL_W, '0, 1'b0, rd);
      chk("cal_reset", CAL_RESET, rd);
      for (i = 0; i < 50000 && shadow_loaded !== 1'b1; i++) @(negedge clk);
      chk("loaded", 1'b1, shadow_loaded);
      @(negedge clk);
      chk("pend_valid", 1'b1, cal_valid);
      chk("pend_const", pick(cal_exp, 1'b1, 2'h2, 3'h0), cal_const);
      chk("cells_read", FUSE_BITS, falls);
      chk("rd_en_done", 1'b0, fuse_rd_en);
      chk("spare", 5'h15, spare);
      chk("trim_load", 20'hB2C47, trim_total);
      chk("trim_fields", 20'hB2C47, {t_src, t_amp, t_abs, t_tc});
      host_xfer(1'b1, CAL_W, '0, 1'b0, rd);
      chk("cal_read", cal_exp, rd);
      $display("test power_up done");
      // every selection code, the ignored bits varied
      for (i = 0; i < 4; i++) meas(1'b1, 2'(i), 3'(7 - i));
      for (i = 0; i < 8; i++) meas(1'b0, 2'(i), 3'(i));
      $display("test select done");
      // host overwrites the fuse constants
      host_xfer(1'b1, CAL_W, ~cal_exp, 1'b1, rd);
      chk("cal_old", cal_exp, rd);
      cal_exp = ~cal_exp;
      meas(1'b0, 2'h1, 3'h5);
      meas(1'b1, 2'h3, 3'h6);
      host_xfer(1'b1, CAL_W, '0, 1'b0, rd);
      chk("cal_back", cal_exp, rd);
      $display("test cal_write done");
      // trim writes across the source trim sign and magnitude ends
      tprev = 20'hB2C47;
      for (i = 0; i < 6; i++)
      begin
         tw = {codes[i], 5'h0A, 5'h13, 5'h1C};
         host_xfer(1'b0, TRIM_W, CAL_W'(tw), 1'b1, rd);
         chk("trim_old", tprev, rd);
         chk("trim_new", tw, trim_total);
         chk("trim_flds", tw, {t_src, t_amp, t_abs, t_tc});
         @(negedge clk);
         chk("steps", 6'(codes[i][4] ? 6'h10 - 6'(codes[i][3:0]) : -6'(codes[i][3:0])),
             steps);
         tprev = tw;
      end
      $display("test trim_write done");
      close_out();
   end
endmodule
